//--- verilog/tscp_pkg.sv
package tscp_pkg;
  // Frame layout
  localparam int TSCP_ADDR_W  = 5;
  localparam int TSCP_DATA_W  = 26;
  localparam int TSCP_FRAME_W = 32;
  localparam int TSCP_NREG    = 32;
  localparam int TSCP_RW_BIT  = 31;
  localparam int TSCP_ADDR_LO = 26;
  localparam logic TSCP_RW_READ = 1'h1;
  // Register addresses
  localparam logic [4:0] TSCP_REG_ENABLE = 5'h00;
  localparam logic [4:0] TSCP_REG_MISC2  = 5'h04;
  localparam logic [4:0] TSCP_REG_SYN    = 5'h0F;
  localparam logic [4:0] TSCP_REG_MISC   = 5'h10;
  // Field positions
  localparam int TSCP_TSEN_BIT     = 14;
  localparam int TSCP_TRIG_BIT     = 6;
  localparam int TSCP_TEMP_LO      = 7;
  localparam int TSCP_TEMP_W       = 5;
  localparam int TSCP_DCOR_BIT     = 22;
  localparam int TSCP_RCDIV_BIT    = 20;
  localparam int TSCP_DUP_LO       = 0;
  localparam int TSCP_DDN_LO       = 8;
  localparam int TSCP_DITH_W       = 8;
  localparam int TSCP_BLKEN_W      = 19;
  // Power mode block enable patterns
  localparam logic [18:0] TSCP_PM_SLEEP   = 19'h00000;
  localparam logic [18:0] TSCP_PM_RXIDLE  = 19'h00840;
  localparam logic [18:0] TSCP_PM_TXIDLE  = 19'h01000;
  localparam logic [18:0] TSCP_PM_DUPLEX  = 19'h79BFF;
  localparam logic [18:0] TSCP_PM_RXONLY  = 19'h009FF;
  localparam logic [18:0] TSCP_PM_TXONLY  = 19'h79240;
  // Timing
  localparam int TSCP_CLK_MHZ      = 100;
  localparam int TSCP_CONV_US      = 2;
  localparam int TSCP_CONV_CYC     = TSCP_CONV_US * TSCP_CLK_MHZ;
  localparam int TSCP_POWERUP_US   = 100;
  localparam int TSCP_POWERUP_CYC  = TSCP_POWERUP_US * TSCP_CLK_MHZ;
  localparam int TSCP_SCLK_HALF    = 4;
  localparam int TSCP_CS_GAP       = 8;
endpackage : tscp_pkg

//--- verilog/tscp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tscp_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  modport host (output cs_n, output sclk, output din, input dout);
  modport dev  (input cs_n, input sclk, input din, output dout);
endinterface : tscp_link_if
`default_nettype wire

//--- verilog/tscp_device.sv
`timescale 1ns/1ns
`default_nettype none
module tscp_device
  import tscp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Serial link
  tscp_link_if.dev         link,
  // Sensor reading
  input  wire logic [4:0]  temp_sample_i,
  // Decoded controls and frame error flag
  output logic [18:0]      block_enable_o,
  output logic             sensor_enable_o,
  output logic             recovery_divider_o,
  output logic [7:0]       dither_up_count_o,
  output logic [7:0]       dither_down_count_o,
  output logic             dither_correction_enable_o,
  output logic             frame_error_o
);
  // Register array kept apart: no reset on purpose
  logic [TSCP_DATA_W-1:0] regs [TSCP_NREG];

  typedef struct packed {
    logic [2:0]  cs_s;
    logic [2:0]  sck_s;
    logic [1:0]  din_s;
    logic [31:0] shift;
    logic [5:0]  count;
    logic        rd;
    logic [25:0] rdata;
    logic        dout;
    logic        trig_prev;
    logic        busy;
    logic [15:0] conv_cnt;
    logic [4:0]  temp;
    logic [18:0] blk;
    logic        tsen;
    logic        rcdiv;
    logic [7:0]  dup;
    logic [7:0]  ddn;
    logic        dcor;
    logic        ferr;
  } tscp_dev_s;

  tscp_dev_s st;
  tscp_dev_s next_st;
  logic      wr_en;
  logic [4:0] wr_addr;
  logic [25:0] wr_data;

  always_comb begin
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic [31:0] sh;
    cs_rise  = st.cs_s[1] & ~st.cs_s[2];
    cs_fall  = ~st.cs_s[1] & st.cs_s[2];
    sck_rise = st.sck_s[1] & ~st.sck_s[2];
    sck_fall = ~st.sck_s[1] & st.sck_s[2];
    sh       = st.shift;
    next_st = st;
    wr_en   = 1'b0;
    wr_addr = st.shift[TSCP_ADDR_LO +: TSCP_ADDR_W];
    wr_data = st.shift[TSCP_DATA_W-1:0];
    next_st.cs_s  = {st.cs_s[1:0], link.cs_n};
    next_st.sck_s = {st.sck_s[1:0], link.sclk};
    next_st.din_s = {st.din_s[0], link.din};
    if (cs_fall) begin
      next_st.count = '0;
      next_st.rd    = 1'b0;
      next_st.dout  = 1'b0;
    end else if (!st.cs_s[1]) begin
      if (sck_rise) begin
        sh = {st.shift[30:0], st.din_s[1]};
        next_st.shift = sh;
        if (st.count != 6'h3F) next_st.count = st.count + 6'h01;
        if (st.count == 6'(TSCP_ADDR_W)) begin
          next_st.rd = sh[TSCP_ADDR_W] == TSCP_RW_READ;
          next_st.rdata = regs[sh[TSCP_ADDR_W-1:0]];
          if (sh[TSCP_ADDR_W-1:0] == TSCP_REG_MISC2) begin
            next_st.rdata[TSCP_TEMP_LO +: TSCP_TEMP_W] = st.temp;
          end
        end
      end
      if (sck_fall && st.rd) begin
        next_st.dout  = st.rdata[TSCP_DATA_W-1];
        next_st.rdata = {st.rdata[TSCP_DATA_W-2:0], 1'b0};
      end
    end
    if (cs_rise) begin
      next_st.dout = 1'b0;
      next_st.ferr = st.count != 6'(TSCP_FRAME_W);
      if (st.count == 6'(TSCP_FRAME_W) && st.shift[TSCP_RW_BIT] != TSCP_RW_READ) begin
        wr_en = 1'b1;
      end
    end
    // Countdown first, so a new trigger in the same cycle wins
    if (st.busy) begin
      if (st.conv_cnt == '0) begin
        next_st.busy = 1'b0;
        next_st.temp = temp_sample_i;
      end else begin
        next_st.conv_cnt = st.conv_cnt - 16'h0001;
      end
    end
    // Decoded controls follow the latched register
    if (wr_en) begin
      unique case (wr_addr)
        TSCP_REG_ENABLE: begin
          next_st.blk  = wr_data[TSCP_BLKEN_W-1:0];
          next_st.tsen = wr_data[TSCP_TSEN_BIT];
        end
        TSCP_REG_MISC2: begin
          next_st.trig_prev = wr_data[TSCP_TRIG_BIT];
          if (wr_data[TSCP_TRIG_BIT] && !st.trig_prev && st.tsen) begin
            next_st.busy     = 1'b1;
            next_st.conv_cnt = 16'(TSCP_CONV_CYC - 1);
          end
        end
        TSCP_REG_SYN: next_st.dcor = wr_data[TSCP_DCOR_BIT];
        TSCP_REG_MISC: begin
          next_st.dup   = wr_data[TSCP_DUP_LO +: TSCP_DITH_W];
          next_st.ddn   = wr_data[TSCP_DDN_LO +: TSCP_DITH_W];
          next_st.rcdiv = wr_data[TSCP_RCDIV_BIT];
        end
        default: ;
      endcase
    end
    if (!next_st.tsen) begin
      next_st.temp = '0;
      next_st.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.cs_s <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en) regs[wr_addr] <= wr_data;
  end

  assign link.dout                  = st.dout;
  assign block_enable_o             = st.blk;
  assign sensor_enable_o            = st.tsen;
  assign recovery_divider_o         = st.rcdiv;
  assign dither_up_count_o          = st.dup;
  assign dither_down_count_o        = st.ddn;
  assign dither_correction_enable_o = st.dcor;
  assign frame_error_o              = st.ferr;
endmodule : tscp_device
`default_nettype wire

//--- verilog/tscp_host.sv
`timescale 1ns/1ns
`default_nettype none
module tscp_host
  import tscp_pkg::*;
#(
  parameter int POWERUP_CYCLES = TSCP_POWERUP_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Serial link
  tscp_link_if.host        link,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  // Word 0: command (write starts a frame); word 1: status/result
  localparam logic [3:0] HOST_CMD = 4'h0;
  localparam logic [3:0] HOST_STS = 4'h1;

  typedef enum logic [1:0] {
    TSCP_IDLE = 2'b00,
    TSCP_XFER = 2'b01,
    TSCP_GAP  = 2'b10
  } tscp_state_e;

  typedef struct packed {
    tscp_state_e state;
    logic [15:0] pwr_cnt;
    logic        ready;
    logic [31:0] shift;
    logic [25:0] rdata;
    logic [5:0]  bits;
    logic [3:0]  div;
    logic        sclk;
    logic        cs_n;
    logic [1:0]  dout_s;
    logic        wait_r;
    logic [31:0] rd_out;
  } tscp_host_s;

  tscp_host_s st;
  tscp_host_s next_st;

  always_comb begin
    next_st = st;
    next_st.dout_s = {st.dout_s[0], link.dout};
    next_st.wait_r = 1'b1;
    if (st.pwr_cnt != '0) next_st.pwr_cnt = st.pwr_cnt - 16'h0001;
    else next_st.ready = 1'b1;
    if (avs_read && st.wait_r) begin
      next_st.wait_r = 1'b0;
      next_st.rd_out = (avs_address == HOST_STS)
        ? {4'h0, st.ready, st.state != TSCP_IDLE, st.rdata} : 32'h0;
    end
    if (avs_write && st.wait_r) begin
      if (avs_address != HOST_CMD) begin
        next_st.wait_r = 1'b0;
      end else if (st.state == TSCP_IDLE && st.ready) begin
        next_st.wait_r = 1'b0;
        next_st.shift  = avs_writedata;
        next_st.state  = TSCP_XFER;
        next_st.cs_n   = 1'b0;
        next_st.bits   = '0;
        next_st.div    = '0;
      end
    end
    unique case (st.state)
      TSCP_IDLE: ;
      TSCP_XFER: begin
        next_st.div = st.div + 4'h1;
        if (st.div == 4'(TSCP_SCLK_HALF - 1)) begin
          next_st.div = '0;
          if (!st.sclk) begin
            next_st.sclk = 1'b1;
            next_st.bits = st.bits + 6'h01;
          end else begin
            // Sample at end of high phase; read data lags the fall by both synchronisers
            if (st.bits > 6'(TSCP_ADDR_W + 1)) begin
              next_st.rdata = {st.rdata[24:0], st.dout_s[1]};
            end
            if (st.bits == 6'(TSCP_FRAME_W)) begin
              next_st.cs_n  = 1'b1;
              next_st.state = TSCP_GAP;
            end else begin
              next_st.sclk  = 1'b0;
              next_st.shift = {st.shift[30:0], 1'b0};
            end
          end
        end
      end
      TSCP_GAP: begin
        next_st.sclk = 1'b0;
        next_st.div  = st.div + 4'h1;
        if (st.div == 4'(TSCP_CS_GAP - 1)) next_st.state = TSCP_IDLE;
      end
      default: next_st.state = TSCP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st         <= '0;
      st.cs_n    <= 1'b1;
      st.wait_r  <= 1'b1;
      st.pwr_cnt <= 16'(POWERUP_CYCLES);
    end else begin
      st <= next_st;
    end
  end

  assign link.cs_n       = st.cs_n;
  assign link.sclk       = st.sclk;
  assign link.din        = st.shift[TSCP_RW_BIT];
  assign avs_readdata    = st.rd_out;
  assign avs_waitrequest = st.wait_r;
endmodule : tscp_host
`default_nettype wire

//--- sim/tscp_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tscp_link_asserts #(
  parameter int POWERUP_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link lines
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout
);
  logic        sclk_q;
  logic [5:0]  rises;
  logic [15:0] age;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Clock rises per frame, cycles since reset
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    rises  <= (reset_i || cs_n) ? 6'h00 : rises + 6'(sclk && !sclk_q);
    age    <= reset_i ? 16'h0000 : age + 16'(age != 16'hFFFF);
  end
  a_powerup_wait: assert property (!cs_n |-> age >= 16'(POWERUP_CYCLES))
    else $error("select low too early");
  a_rise_count: assert property ($rose(cs_n) |-> rises == 6'h20)
    else $error("frame edge count wrong");
  a_frame_span: assert property ($fell(cs_n) |-> ##[250:320] $rose(cs_n))
    else $error("frame length wrong");
  a_idle_clock: assert property (cs_n && $past(cs_n) && !sclk |=> !sclk)
    else $error("clock edge outside frame");
  a_select_fall: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
    else $error("clock high at select fall");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n[*5])
    else $error("select high too short");
  a_data_steady: assert property (!cs_n && sclk |-> $stable(din))
    else $error("data moved while clock high");
  a_clock_high: assert property (!cs_n && $rose(sclk) |-> sclk[*3])
    else $error("clock high too short");
  a_dout_fall: assert property (!cs_n && !$past(cs_n) && $changed(dout) |-> !$past(sclk))
    else $error("read data moved while clock high");
endmodule : tscp_link_asserts
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import tscp_pkg::*;
;
  localparam int PU = 20;
  logic        clk_i;
  logic        reset_i;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  temp;
  logic [18:0] blk;
  logic [18:0] blk2;
  logic        sens;
  logic        rdiv;
  logic [7:0]  dup;
  logic [7:0]  ddn;
  logic        dcor;
  logic        ferr;
  logic        ferr2;
  logic [31:0] q;
  int          fail_count;
  int          check_count;
  tscp_link_if lk ();
  tscp_link_if lk2 ();
  tscp_host #(.POWERUP_CYCLES(PU)) i_tscp_host (.clk_i(clk_i), .reset_i(reset_i), .link(lk.host),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  tscp_device i_tscp_device (.clk_i(clk_i), .reset_i(reset_i), .link(lk.dev), .temp_sample_i(temp),
    .block_enable_o(blk), .sensor_enable_o(sens), .recovery_divider_o(rdiv),
    .dither_up_count_o(dup), .dither_down_count_o(ddn), .dither_correction_enable_o(dcor),
    .frame_error_o(ferr));
  tscp_device i_tscp_device_fault (.clk_i(clk_i), .reset_i(reset_i), .link(lk2.dev),
    .temp_sample_i(5'h00), .block_enable_o(blk2), .sensor_enable_o(), .recovery_divider_o(),
    .dither_up_count_o(), .dither_down_count_o(), .dither_correction_enable_o(),
    .frame_error_o(ferr2));
  tscp_link_asserts #(.POWERUP_CYCLES(PU)) i_tscp_link_asserts (.clk_i(clk_i),
    .reset_i(reset_i), .cs_n(lk.cs_n), .sclk(lk.sclk), .din(lk.din), .dout(lk.dout));
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 3000);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      results();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av
  // Frame through the host, waits until idle
  task automatic frame(input logic rw, input logic [4:0] a, input logic [25:0] d);
    int n;
    av(1'b1, 4'h0, {rw, a, d});
    n = 0;
    do begin
      av(1'b0, 4'h1, 32'h0);
      n++;
    end while (q[26] !== 1'b0 && n < 500);
    if (q[26] !== 1'b0) begin
      fail_count++;
      results();
    end
    repeat (TSCP_CS_GAP) @(posedge clk_i);
  endtask : frame
  task automatic rd(input logic [4:0] a);
    frame(TSCP_RW_READ, a, 26'h0000000);
    av(1'b0, 4'h1, 32'h0);
  endtask : rd
  // Bit-banged frame of n bits on the second link
  task automatic bb(input int n, input logic [31:0] w);
    lk2.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      lk2.din <= w[31-i];
      repeat (6) @(posedge clk_i);
      lk2.sclk <= 1'b1;
      repeat (6 + (i % 2)) @(posedge clk_i);
      lk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    lk2.cs_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : bb
  task automatic t_power();
    av(1'b0, 4'h1, 32'h0);
    chk(q[27], 1'b0);
    frame(1'b0, TSCP_REG_SYN, 26'h0400000);
    chk(dcor, 1'b1);
    frame(1'b0, TSCP_REG_SYN, 26'h0000000);
    chk(dcor, 1'b0);
    av(1'b1, 4'h9, 32'hFFFFFFFF);
    av(1'b0, 4'h1, 32'h0);
    chk(q[27:26], 2'h2);
    $display("power test done");
  endtask : t_power
  task automatic t_modes();
    logic [18:0] pm [6] = '{TSCP_PM_SLEEP, TSCP_PM_RXIDLE, TSCP_PM_TXIDLE, TSCP_PM_DUPLEX,
                            TSCP_PM_RXONLY, TSCP_PM_TXONLY};
    logic        tx;
    logic [7:0]  up;
    logic [7:0]  dn;
    for (int i = 0; i < 6; i++) begin
      tx = (i == 2 || i == 3 || i == 5);
      up = 8'(i * 51);
      dn = ~up;
      frame(1'b0, TSCP_REG_ENABLE, {7'h00, pm[i]});
      frame(1'b0, TSCP_REG_MISC, {5'h00, tx, 4'h0, dn, up});
      chk(blk, pm[i]);
      chk(sens, 1'b0);
      chk(rdiv, tx);
      chk({ddn, dup}, {dn, up});
    end
    $display("mode test done");
  endtask : t_modes
  task automatic t_regs();
    for (int a = 0; a < 32; a++) frame(1'b0, 5'(a), {5'(a), 21'h0A5A5});
    chk(ferr, 1'b0);
    for (int a = 0; a < 32; a++) begin
      if (a != 4) begin
        rd(5'(a));
        chk(q[25:0], {5'(a), 21'h0A5A5});
      end
    end
    $display("register test done");
  endtask : t_regs
  task automatic t_temp();
    temp <= 5'h13;
    frame(1'b0, TSCP_REG_ENABLE, 26'h0004000);
    chk(sens, 1'b1);
    frame(1'b0, TSCP_REG_MISC2, 26'h0000000);
    frame(1'b0, TSCP_REG_MISC2, 26'h0000040);
    repeat (TSCP_CONV_CYC) @(posedge clk_i);
    temp <= 5'h0C;
    rd(TSCP_REG_MISC2);
    chk(q[11:7], 5'h13);
    frame(1'b0, TSCP_REG_MISC2, 26'h0000040);
    repeat (TSCP_CONV_CYC) @(posedge clk_i);
    rd(TSCP_REG_MISC2);
    chk(q[11:7], 5'h13);
    frame(1'b0, TSCP_REG_ENABLE, 26'h0000000);
    rd(TSCP_REG_MISC2);
    chk(q[11:7], 5'h00);
    $display("temperature test done");
  endtask : t_temp
  task automatic t_fault();
    bb(32, {1'b0, TSCP_REG_ENABLE, 26'h0000840});
    chk({ferr2, blk2}, {1'b0, TSCP_PM_RXIDLE});
    bb(31, {1'b0, TSCP_REG_ENABLE, 26'h0079BFF});
    chk({ferr2, blk2}, {1'b1, TSCP_PM_RXIDLE});
    $display("fault test done");
  endtask : t_fault
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    reset_i = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    temp = 5'h00;
    lk2.cs_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.din = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    t_power();
    t_modes();
    t_regs();
    t_temp();
    t_fault();
    results();
  end
endmodule : tb_top
`default_nettype wire
